// ==== core/trig_counter.sv ====
// Event counter with terminal value detection
`timescale 1ns/1ps
module trig_counter
   import trig_pkg::*;
#(
   parameter int W = CNT_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control link
   trig_count_if.unit cnt
);
   typedef struct packed {
      logic [W-1:0] value;
      logic hit;
   } cnt_s;

   cnt_s st_reg;
   cnt_s st_next;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      st_next.hit = 1'b0;
      if (!cnt.enable) begin
         st_next.value = st_reg.value;
      end else if (cnt.clear) begin
         st_next.value = '0;
      end else if (cnt.step) begin
         st_next.value = st_reg.value + 1'b1;
         // Fires once, on the step that lands on the limit
         st_next.hit = (st_next.value == cnt.limit);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cnt.value = st_reg.value;
   assign cnt.hit = st_reg.hit;

   ////////////////////////////////////////////////////////////////////////////
   property p_cnt_clear;
      @(posedge clk_i) disable iff (rst_i)
      (cnt.enable && cnt.clear) |=> (cnt.value == '0) && !cnt.hit;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");
endmodule

// ==== core/trig_timer.sv ====
// Start/stop trigger timer with compare value
`timescale 1ns/1ps
module trig_timer
   import trig_pkg::*;
#(
   parameter int W = TIMER_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Processor clock tick
   input wire logic tick_i,
   // Control link
   trig_count_if.unit tmr
);
   typedef struct packed {
      logic run;
      logic [W-1:0] value;
      logic hit;
   } tmr_s;

   tmr_s st_reg;
   tmr_s st_next;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      st_next.hit = 1'b0;
      if (!tmr.enable) begin
         st_next.run = 1'b0;
      end else begin
         if (tmr.step) begin
            st_next.run = 1'b1;
         end
         if (tmr.halt) begin
            st_next.run = 1'b0;
         end
         if (tmr.clear) begin
            st_next.value = '0;
         end else if (st_reg.run && tick_i) begin
            // Natural W-bit overflow gives the wrap back to zero
            st_next.value = st_reg.value + 1'b1;
            st_next.hit = (st_next.value == tmr.limit);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tmr.value = st_reg.value;
   assign tmr.hit = st_reg.hit;

   ////////////////////////////////////////////////////////////////////////////
   property p_tmr_wrap;
      @(posedge clk_i) disable iff (rst_i)
      (tmr.enable && st_reg.run && tick_i && !tmr.clear && (&st_reg.value)) |=> (tmr.value == '0);
   endproperty
   a_tmr_wrap: assert property (p_tmr_wrap) else $error("timer did not wrap");
endmodule

// ==== core/trigger_sequencer.sv ====
// Four-level trigger sequencer with Wishbone register access
`timescale 1ns/1ps
module trigger_sequencer
   import trig_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Target pins
   input wire logic proc_clk_i,
   input wire logic bus_cycle_i,
   input wire logic [NUM_EVENTS-1:0] event_match_i,
   input wire logic ext_trig_n_i,
   // Actions
   output logic break_o,
   output logic trace_on_o,
   output logic trace_next_o,
   output logic trigger_out_o,
   output logic [1:0] level_o,
   output logic irq_o
);
   typedef struct packed {
      logic [NUM_EVENTS-1:0] ev_s1;
      logic [NUM_EVENTS-1:0] ev_s2;
      logic pclk_s1;
      logic pclk_s2;
      logic pclk_d;
      logic bus_s1;
      logic bus_s2;
      logic bus_d;
      logic extn_s1;
      logic extn_s2;
      logic [3:0] ctrl;
      logic [INT_W-1:0] int_stat;
      logic [INT_W-1:0] int_mask;
      logic [CNT_W-1:0] lim_a;
      logic [CNT_W-1:0] lim_b;
      logic [TIMER_W-1:0] lim_t;
      logic [NUM_LEVELS-1:0][NUM_ROWS-1:0][ROW_W-1:0] rows;
      level_e level;
      logic brk;
      logic trace_on;
      logic trace_next;
      logic trig_out;
      logic irq;
      logic ack;
      logic [31:0] rdata;
   } seq_s;

   seq_s st_reg;
   seq_s st_next;

   trig_count_if #(.W(CNT_W)) cnt_a ();
   trig_count_if #(.W(CNT_W)) cnt_b ();
   trig_count_if #(.W(TIMER_W)) tmr ();

   logic tick;
   logic sample;
   logic armed;
   logic cnt_en;
   logic tmr_en;
   logic [NUM_ROWS-1:0] match;
   logic [NUM_ROWS-1:0] fire;
   logic [NUM_ROWS-1:0] en_vec;
   logic [NUM_ROWS-1:0] extq_vec;
   logic [NUM_ROWS:0][ROW_W-1:0] act_chain;
   logic [ROW_W-1:0] acts;
   logic [ROW_W-1:0] cur_row [NUM_ROWS];
   logic bus_req;
   logic wr;
   logic rd;
   logic [31:0] wmask;
   logic row_hit;
   logic [1:0] row_lvl;
   logic [3:0] row_idx;
   logic restart;

   ////////////////////////////////////////////////////////////////////////////
   // Sampling strobes
   assign tick = st_reg.pclk_s2 && !st_reg.pclk_d;
   assign sample = st_reg.ctrl[CTRL_CLOCK_MODE] ? tick :
      (st_reg.bus_d && !st_reg.bus_s2);
   assign armed = st_reg.ctrl[CTRL_ARM] && !st_reg.brk;
   assign cnt_en = st_reg.ctrl[CTRL_CNT_EN];
   assign tmr_en = st_reg.ctrl[CTRL_TMR_EN];

   ////////////////////////////////////////////////////////////////////////////
   // Row evaluation for the active level only
   assign act_chain[0] = '0;
   genvar r;
   generate
      for (r = 0; r < NUM_ROWS; r++) begin : g_row
         assign cur_row[r] = st_reg.rows[st_reg.level][r];
         assign en_vec[r] = cur_row[r][ROW_EN];
         assign extq_vec[r] = cur_row[r][ROW_EXTQ];
         if (r < NUM_EVENTS) begin : g_ev
            assign match[r] = sample && st_reg.ev_s2[r];
         end else if (r == ROW_CNT_A) begin : g_ca
            assign match[r] = cnt_en && cnt_a.hit;
         end else if (r == ROW_CNT_B) begin : g_cb
            assign match[r] = cnt_en && cnt_b.hit;
         end else if (r == ROW_TMR) begin : g_tm
            assign match[r] = tmr_en && tmr.hit;
         end else begin : g_ex
            assign match[r] = sample && !st_reg.extn_s2;
         end
         assign fire[r] = armed && en_vec[r] && match[r] &&
            (!extq_vec[r] || !st_reg.extn_s2);
         assign act_chain[r+1] = act_chain[r] | (fire[r] ? cur_row[r] : '0);
      end
   endgenerate
   assign acts = act_chain[NUM_ROWS];

   ////////////////////////////////////////////////////////////////////////////
   // Counting units
   assign cnt_a.enable = cnt_en;
   assign cnt_a.step = acts[ACT_INC_A];
   assign cnt_a.clear = acts[ACT_CLR_A] || restart;
   assign cnt_a.halt = 1'b0;
   assign cnt_a.limit = st_reg.lim_a;
   assign cnt_b.enable = cnt_en;
   assign cnt_b.step = acts[ACT_INC_B];
   assign cnt_b.clear = acts[ACT_CLR_B] || restart;
   assign cnt_b.halt = 1'b0;
   assign cnt_b.limit = st_reg.lim_b;
   assign tmr.enable = tmr_en;
   assign tmr.step = acts[ACT_TMR_START];
   assign tmr.halt = acts[ACT_TMR_STOP];
   assign tmr.clear = acts[ACT_TMR_CLR] || restart;
   assign tmr.limit = st_reg.lim_t;

   trig_counter #(.W(CNT_W)) u_cnt_a (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cnt(cnt_a)
   );
   trig_counter #(.W(CNT_W)) u_cnt_b (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cnt(cnt_b)
   );
   trig_timer #(.W(TIMER_W)) u_tmr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .tmr(tmr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign bus_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
   assign wr = bus_req && wb_we_i;
   assign rd = bus_req && !wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign row_lvl = wb_adr_i[7:6];
   assign row_idx = wb_adr_i[5:2];
   assign row_hit = (wb_adr_i[9:8] == ROW_PAGE) && (row_idx < 4'(NUM_ROWS));
   assign restart = wr && (wb_adr_i == OFF_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_RESTART];

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      level_e adv;
      logic [INT_W-1:0] ev;
      logic [31:0] rv;
      adv = LEVEL_0;
      ev = '0;
      rv = '0;
      st_next = st_reg;
      // Synchronisers; first stage feeds only the second
      st_next.ev_s1 = event_match_i;
      st_next.ev_s2 = st_reg.ev_s1;
      st_next.pclk_s1 = proc_clk_i;
      st_next.pclk_s2 = st_reg.pclk_s1;
      st_next.pclk_d = st_reg.pclk_s2;
      st_next.bus_s1 = bus_cycle_i;
      st_next.bus_s2 = st_reg.bus_s1;
      st_next.bus_d = st_reg.bus_s2;
      st_next.extn_s1 = ext_trig_n_i;
      st_next.extn_s2 = st_reg.extn_s1;

      // Level stepping; last level holds
      case (st_reg.level)
         LEVEL_0: adv = LEVEL_1;
         LEVEL_1: adv = LEVEL_2;
         LEVEL_2: adv = LEVEL_3;
         LEVEL_3: adv = LEVEL_3;
         default: adv = LEVEL_0;
      endcase

      // Actions of all firing rows, merged
      st_next.trace_next = acts[ACT_NEXT];
      if (acts[ACT_RST]) begin
         st_next.level = LEVEL_0;
      end else if (acts[ACT_SEQ]) begin
         st_next.level = adv;
      end
      if (acts[ACT_BRK]) begin
         st_next.brk = 1'b1;
      end
      if (acts[ACT_TOFF]) begin
         st_next.trace_on = 1'b0;
      end
      // Low wins when both drive directions are requested
      if (acts[ACT_OUT_LO]) begin
         st_next.trig_out = 1'b0;
      end else if (acts[ACT_OUT_HI]) begin
         st_next.trig_out = 1'b1;
      end

      ev[INT_BREAK] = acts[ACT_BRK];
      ev[INT_LEVEL] = acts[ACT_SEQ] && !acts[ACT_RST];
      ev[INT_CNT_A] = cnt_a.hit;
      ev[INT_CNT_B] = cnt_b.hit;
      ev[INT_TMR] = tmr.hit;
      ev[INT_TOFF] = acts[ACT_TOFF];

      // Register writes
      if (wr) begin
         case (wb_adr_i)
            OFF_CTRL: st_next.ctrl = 4'((st_reg.ctrl & ~wmask) | (wb_dat_i & wmask));
            OFF_INT_MASK: st_next.int_mask = INT_W'((st_reg.int_mask & ~wmask) | (wb_dat_i & wmask));
            OFF_CNT_A_LIMIT: st_next.lim_a = CNT_W'((st_reg.lim_a & ~wmask) | (wb_dat_i & wmask));
            OFF_CNT_B_LIMIT: st_next.lim_b = CNT_W'((st_reg.lim_b & ~wmask) | (wb_dat_i & wmask));
            OFF_TMR_LIMIT: st_next.lim_t = TIMER_W'((st_reg.lim_t & ~wmask) | (wb_dat_i & wmask));
            default: begin
               if (row_hit) begin
                  st_next.rows[row_lvl][row_idx] =
                     ROW_W'((st_reg.rows[row_lvl][row_idx] & ~wmask) | (wb_dat_i & wmask));
               end
            end
         endcase
      end
      // Software restart overrides level, break, trace-on and trigger-out actions of the same cycle
      if (restart) begin
         st_next.level = LEVEL_0;
         st_next.brk = 1'b0;
         st_next.trace_on = TRACE_ON_RST;
         st_next.trig_out = TRIG_OUT_RST;
      end

      // Register reads; unmapped reads return zero
      case (wb_adr_i)
         OFF_CTRL: rv = 32'(st_reg.ctrl);
         OFF_STATUS: rv = 32'({st_reg.trig_out, st_reg.trace_on, st_reg.brk, st_reg.level});
         OFF_INT_STAT: rv = 32'(st_reg.int_stat);
         OFF_INT_MASK: rv = 32'(st_reg.int_mask);
         OFF_CNT_A_LIMIT: rv = 32'(st_reg.lim_a);
         OFF_CNT_B_LIMIT: rv = 32'(st_reg.lim_b);
         OFF_TMR_LIMIT: rv = 32'(st_reg.lim_t);
         OFF_TMR_VALUE: rv = 32'(tmr.value);
         OFF_CNT_A_VALUE: rv = 32'(cnt_a.value);
         OFF_CNT_B_VALUE: rv = 32'(cnt_b.value);
         default: rv = row_hit ? 32'(st_reg.rows[row_lvl][row_idx]) : 32'h0000_0000;
      endcase
      st_next.ack = bus_req;
      if (rd) begin
         st_next.rdata = rv;
      end

      // Read clears status; a new event in that cycle survives
      if (rd && (wb_adr_i == OFF_INT_STAT)) begin
         st_next.int_stat = ev;
      end else begin
         st_next.int_stat = st_reg.int_stat | ev;
      end
      st_next.irq = |(st_reg.int_stat & st_reg.int_mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
         st_reg.ctrl <= CTRL_RST;
         st_reg.trace_on <= TRACE_ON_RST;
         st_reg.trig_out <= TRIG_OUT_RST;
         st_reg.pclk_s1 <= 1'b0;
         st_reg.extn_s1 <= 1'b1;
         st_reg.extn_s2 <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_dat_o = st_reg.rdata;
   assign wb_ack_o = st_reg.ack;
   assign break_o = st_reg.brk;
   assign trace_on_o = st_reg.trace_on;
   assign trace_next_o = st_reg.trace_next;
   assign trigger_out_o = st_reg.trig_out;
   assign level_o = st_reg.level;
   assign irq_o = st_reg.irq;

   ////////////////////////////////////////////////////////////////////////////
   property p_row_gate;
      @(posedge clk_i) disable iff (rst_i)
      (fire & ~en_vec) == '0;
   endproperty
   a_row_gate: assert property (p_row_gate) else $error("disabled row fired");

   property p_ext_qual;
      @(posedge clk_i) disable iff (rst_i)
      |(fire & extq_vec) |-> !st_reg.extn_s2;
   endproperty
   a_ext_qual: assert property (p_ext_qual) else $error("qualified row fired with input high");

   property p_break;
      @(posedge clk_i) disable iff (rst_i)
      (acts[ACT_BRK] && !restart) |=> break_o ##1 (break_o || $past(restart));
   endproperty
   a_break: assert property (p_break) else $error("break action lost");

   property p_seq;
      @(posedge clk_i) disable iff (rst_i)
      (acts[ACT_SEQ] && !acts[ACT_RST] && !restart && level_o != 2'h3)
         |=> level_o == $past(level_o) + 2'h1;
   endproperty
   a_seq: assert property (p_seq) else $error("level did not advance by one");

   property p_reset_level;
      @(posedge clk_i) disable iff (rst_i)
      acts[ACT_RST] |=> level_o == 2'h0;
   endproperty
   a_reset_level: assert property (p_reset_level) else $error("reset action kept level");

   property p_bus_sample;
      @(posedge clk_i) disable iff (rst_i)
      (!st_reg.ctrl[CTRL_CLOCK_MODE] && |fire[NUM_EVENTS-1:0]) |-> (st_reg.bus_d && !st_reg.bus_s2);
   endproperty
   a_bus_sample: assert property (p_bus_sample) else $error("event fired off bus sample");

   property p_irq;
      @(posedge clk_i) disable iff (rst_i)
      ##1 irq_o == $past(|(st_reg.int_stat & st_reg.int_mask));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt output mismatch");

   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack timing wrong");
endmodule

// ==== include/trig_count_if.sv ====
// Control and status link between sequencer and its counting units
`timescale 1ns/1ps
interface trig_count_if #(parameter int W = 16);
   logic enable;
   logic step;
   logic clear;
   logic halt;
   logic [W-1:0] limit;
   logic [W-1:0] value;
   logic hit;
   modport ctl (output enable, step, clear, halt, limit, input value, hit);
   modport unit (input enable, step, clear, halt, limit, output value, hit);
endinterface

// ==== include/trig_pkg.sv ====
// Shared constants and types for the trigger sequencer
package trig_pkg;
   ////////////////////////////////////////////////////////////////////////////
   localparam int NUM_LEVELS = 4;
   localparam int NUM_EVENTS = 8;
   localparam int NUM_ROWS = 12;
   localparam int ROW_SLOTS = 16;
   localparam int ROW_CNT_A = 8;
   localparam int ROW_CNT_B = 9;
   localparam int ROW_TMR = 10;
   localparam int ROW_EXT = 11;
   localparam int ROW_W = 16;
   localparam int CNT_W = 16;
   localparam int TIMER_W = 20;
   localparam int ADR_W = 10;
   localparam int INT_W = 6;
   ////////////////////////////////////////////////////////////////////////////
   // Row word fields
   localparam int ROW_EN = 0;
   localparam int ROW_EXTQ = 1;
   localparam int ACT_SEQ = 2;
   localparam int ACT_RST = 3;
   localparam int ACT_BRK = 4;
   localparam int ACT_TOFF = 5;
   localparam int ACT_NEXT = 6;
   localparam int ACT_INC_A = 7;
   localparam int ACT_CLR_A = 8;
   localparam int ACT_INC_B = 9;
   localparam int ACT_CLR_B = 10;
   localparam int ACT_OUT_LO = 11;
   localparam int ACT_OUT_HI = 12;
   localparam int ACT_TMR_START = 13;
   localparam int ACT_TMR_STOP = 14;
   localparam int ACT_TMR_CLR = 15;
   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [ADR_W-1:0] OFF_CTRL = 10'h000;
   localparam logic [ADR_W-1:0] OFF_STATUS = 10'h004;
   localparam logic [ADR_W-1:0] OFF_INT_STAT = 10'h008;
   localparam logic [ADR_W-1:0] OFF_INT_MASK = 10'h00c;
   localparam logic [ADR_W-1:0] OFF_CNT_A_LIMIT = 10'h010;
   localparam logic [ADR_W-1:0] OFF_CNT_B_LIMIT = 10'h014;
   localparam logic [ADR_W-1:0] OFF_TMR_LIMIT = 10'h018;
   localparam logic [ADR_W-1:0] OFF_TMR_VALUE = 10'h01c;
   localparam logic [ADR_W-1:0] OFF_CNT_A_VALUE = 10'h020;
   localparam logic [ADR_W-1:0] OFF_CNT_B_VALUE = 10'h024;
   localparam logic [1:0] ROW_PAGE = 2'h1;
   ////////////////////////////////////////////////////////////////////////////
   // Control and interrupt bits, reset values
   localparam int CTRL_CLOCK_MODE = 0;
   localparam int CTRL_CNT_EN = 1;
   localparam int CTRL_TMR_EN = 2;
   localparam int CTRL_ARM = 3;
   localparam int CTRL_RESTART = 4;
   localparam int INT_BREAK = 0;
   localparam int INT_LEVEL = 1;
   localparam int INT_CNT_A = 2;
   localparam int INT_CNT_B = 3;
   localparam int INT_TMR = 4;
   localparam int INT_TOFF = 5;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic TRIG_OUT_RST = 1'b1;
   localparam logic TRACE_ON_RST = 1'b1;

   typedef enum logic [1:0] {
      LEVEL_0 = 2'b00,
      LEVEL_1 = 2'b01,
      LEVEL_2 = 2'b10,
      LEVEL_3 = 2'b11
   } level_e;
endpackage

// ==== test/target_model.sv ====
// Target processor pin model: clock, bus cycles, event and external lines
`timescale 1ns/1ps
module target_model
   import trig_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Requests from the bench
   input wire logic bus_en_i,
   input wire logic [NUM_EVENTS-1:0] event_req_i,
   input wire logic ext_req_i,
   // Target pins
   output logic proc_clk_o,
   output logic bus_cycle_o,
   output logic [NUM_EVENTS-1:0] event_o,
   output logic ext_trig_n_o
);
   logic [3:0] div_reg;
   ////////////////////////////////////////////////////////////////////////////
   // Processor clock at clk/8, below the clk/4 limit of the synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg <= 4'h0;
         proc_clk_o <= 1'b0;
         bus_cycle_o <= 1'b0;
         event_o <= '0;
         ext_trig_n_o <= 1'b1;
      end else begin
         div_reg <= div_reg + 4'h1;
         proc_clk_o <= div_reg[2];
         // One bus cycle per 16 clocks, sample point on its fall
         bus_cycle_o <= bus_en_i & ~div_reg[3];
         event_o <= event_req_i;
         // External line is active low
         ext_trig_n_o <= ~ext_req_i;
      end
   end
endmodule

// ==== test/trigger_sequencer_tb.sv ====
// Self-checking bench for the trigger sequencer
`timescale 1ns/1ps
module trigger_sequencer_tb
   import trig_pkg::*;
   ;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [ADR_W-1:0] wb_adr = '0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack;
   logic bus_en = 1'b1;
   logic [NUM_EVENTS-1:0] ev_req = '0;
   logic ext_req = 1'b0;
   logic proc_clk;
   logic bus_cycle;
   logic [NUM_EVENTS-1:0] ev_pins;
   logic ext_n;
   logic brk;
   logic trace_on;
   logic trace_next;
   logic trig_out;
   logic [1:0] level;
   logic irq;
   logic [4:0] pin_vec;
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;
   int n_next = 0;
   assign pin_vec = {trig_out, trace_on, brk, level};
   ////////////////////////////////////////////////////////////////////////////
   trigger_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack), .proc_clk_i(proc_clk), .bus_cycle_i(bus_cycle), .event_match_i(ev_pins),
      .ext_trig_n_i(ext_n), .break_o(brk), .trace_on_o(trace_on), .trace_next_o(trace_next),
      .trigger_out_o(trig_out), .level_o(level), .irq_o(irq));
   target_model target (.clk_i(clk_i), .rst_i(rst_i), .bus_en_i(bus_en), .event_req_i(ev_req),
      .ext_req_i(ext_req), .proc_clk_o(proc_clk), .bus_cycle_o(bus_cycle), .event_o(ev_pins),
      .ext_trig_n_o(ext_n));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [ADR_W-1:0] row_adr(input int lvl, input int row);
      return {ROW_PAGE, 8'h00} + ADR_W'(lvl * 64 + row * 4);
   endfunction
   task automatic end_sim;
      if (n_fail == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Master waits for ack with no assumed latency
   task automatic wb_cycle(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_sel <= 4'hf;
      wb_dat <= d;
      do @(posedge clk_i); while (wb_ack !== 1'b1);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb_cycle(1'b0, a, 32'h0, q);
      check(q, e);
   endtask
   task automatic drive(input logic [7:0] e, input logic x, input logic b);
      @(posedge clk_i);
      ev_req <= e;
      ext_req <= x;
      bus_en <= b;
   endtask
   // Poll until the pins match the expected value, or wait 120 cycles, and check the pins at the end
   task automatic pins(input logic [4:0] e, input bit poll);
      for (int i = 0; i < 120; i++) begin
         @(negedge clk_i);
         if (poll && pin_vec === e) break;
      end
      check({27'h0, pin_vec}, {27'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Next-buffer output is a one-cycle pulse; count each one
   always @(posedge clk_i) begin
      if (trace_next === 1'b1) begin
         n_next++;
      end
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(OFF_STATUS, 32'h18);
      rd(OFF_CTRL, 32'h0);
      wr(10'h080, 32'hffff_ffff);
      rd(10'h080, 32'h0);
      wr(OFF_TMR_LIMIT, 32'hffff_ffff);
      rd(OFF_TMR_LIMIT, 32'h000f_ffff);
      wr(row_adr(0, 6), 32'h10);
      wr(row_adr(0, 0), 32'h5);
      wr(row_adr(1, 1), 32'h805);
      wr(row_adr(2, 2), 32'h1007);
      wr(row_adr(3, 3), 32'h5);
      wr(row_adr(3, 4), 32'h11);
      wr(row_adr(3, 5), 32'h821);
      wr(OFF_CTRL, 32'h8);
      drive(8'h40, 1'b0, 1'b1);
      pins(5'h18, 0);
      drive(8'h41, 1'b0, 1'b1);
      pins(5'h19, 1);
      pins(5'h19, 0);
      drive(8'h43, 1'b0, 1'b1);
      pins(5'h0a, 1);
      drive(8'h47, 1'b0, 1'b1);
      pins(5'h0a, 0);
      drive(8'h47, 1'b1, 1'b1);
      pins(5'h1b, 1);
      drive(8'h4f, 1'b1, 1'b1);
      pins(5'h1b, 0);
      check({31'h0, irq}, 32'h0);
      drive(8'h7f, 1'b1, 1'b1);
      pins(5'h07, 1);
      pins(5'h07, 0);
      wr(OFF_INT_MASK, 32'h1);
      rd(OFF_STATUS, 32'h07);
      check({31'h0, irq}, 32'h1);
      rd(OFF_INT_STAT, 32'h23);
      repeat (2) @(negedge clk_i);
      check({31'h0, irq}, 32'h0);
      // Counter A counts event 7 and breaks at its limit
      drive(8'h00, 1'b0, 1'b1);
      wr(row_adr(0, 7), 32'h81);
      wr(row_adr(0, ROW_CNT_A), 32'h11);
      wr(OFF_CNT_A_LIMIT, 32'h3);
      wr(OFF_CTRL, 32'h18);
      drive(8'h80, 1'b0, 1'b1);
      pins(5'h18, 0);
      rd(OFF_CNT_A_VALUE, 32'h0);
      wr(OFF_CTRL, 32'ha);
      pins(5'h1c, 1);
      rd(OFF_CNT_A_VALUE, 32'h3);
      // No bus cycles: bus mode is blind, clock mode is not
      drive(8'h00, 1'b0, 1'b0);
      wr(OFF_CTRL, 32'h1a);
      drive(8'h80, 1'b0, 1'b0);
      pins(5'h18, 0);
      rd(OFF_CNT_A_VALUE, 32'h0);
      wr(OFF_CTRL, 32'hb);
      pins(5'h1c, 1);
      rd(OFF_CNT_A_VALUE, 32'h3);
      // Event 1 starts the timer and pulses next buffer per tick; limit 4 breaks and stops
      drive(8'h02, 1'b0, 1'b0);
      wr(row_adr(0, 1), 32'h2041);
      wr(row_adr(0, ROW_TMR), 32'h4011);
      wr(OFF_TMR_LIMIT, 32'h4);
      wr(OFF_CTRL, 32'h1d);
      pins(5'h1c, 1);
      rd(OFF_TMR_VALUE, 32'h4);
      check(32'(n_next), 32'h5);
      // External low row counts B and advances; level 1 resets to 0; B limit 2 breaks
      drive(8'h00, 1'b1, 1'b0);
      wr(row_adr(0, ROW_EXT), 32'h205);
      wr(row_adr(1, ROW_EXT), 32'h9);
      wr(row_adr(1, ROW_CNT_B), 32'h11);
      wr(OFF_CNT_B_LIMIT, 32'h2);
      wr(OFF_CTRL, 32'h1b);
      pins(5'h1d, 1);
      rd(OFF_CNT_B_VALUE, 32'h2);
      end_sim();
   end
endmodule
